// ### verilog/buffer_pkg.sv
// Shared constants, masks, modes and helpers for the registered buffer pair
package buffer_pkg;

	// Widths of the input word and of one output bank
	localparam int DATA_BITS = 25;
	localparam int BANK_BITS = 14;

	// Per-mode masks over the input word, bit 0 is position 1
	localparam logic [24:0] ACTIVE_SINGLE_MASK  = 25'h1FFFFFF;
	localparam logic [24:0] ACTIVE_DUAL_MASK    = 25'h0003FFF;
	localparam logic [24:0] GATED_SINGLE_MASK   = 25'h1FFFFB6;
	localparam logic [24:0] GATED_LAYOUT_A_MASK = 25'h0003FB6;
	localparam logic [24:0] GATED_LAYOUT_B_MASK = 25'h0001BBF;

	// Position 7 of the input word is the primary chip select
	localparam int PRIMARY_CS_BIT = 6;

	// Timing: system clock, receiver wake-up, link half period
	localparam int CLK_PERIOD_NS      = 100;
	localparam int RX_ACTIVE_TIME_NS  = 10;
	localparam int RX_ACTIVE_CYCLES   =
		(RX_ACTIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LINK_HALF_TIME_NS  = 400;
	localparam int LINK_HALF_CYCLES   = LINK_HALF_TIME_NS / CLK_PERIOD_NS;

	// Controller register map, word addresses
	localparam logic [3:0] CONTROL_OFFSET     = 4'h0;
	localparam logic [3:0] DATA_OFFSET        = 4'h1;
	localparam logic [3:0] CHIP_SELECT_OFFSET = 4'h2;
	localparam logic [3:0] STATUS_OFFSET      = 4'h3;

	// Field positions and reset values
	localparam int CTRL_RELEASE_BIT = 0;
	localparam int CTRL_FANOUT_BIT  = 1;
	localparam int CTRL_LAYOUT_BIT  = 2;
	localparam int STATUS_RESET_BIT = 16;
	localparam logic [2:0]  CONTROL_RESET     = 3'h0;
	localparam logic [24:0] DATA_RESET        = 25'h0000000;
	localparam logic        CHIP_SELECT_RESET = 1'h0;

	typedef enum logic [2:0] {
		MODE_SINGLE = 3'b001,
		MODE_DUAL_A = 3'b010,
		MODE_DUAL_B = 3'b100
	} mode_type;

	function automatic mode_type decode_mode(input logic fanout,
		input logic layout);
		if (!fanout)
			return MODE_SINGLE;
		return layout ? MODE_DUAL_B : MODE_DUAL_A;
	endfunction

	function automatic logic [24:0] active_mask(input mode_type mode);
		return (mode == MODE_SINGLE) ? ACTIVE_SINGLE_MASK : ACTIVE_DUAL_MASK;
	endfunction

	function automatic logic [24:0] gated_mask(input mode_type mode);
		case (mode)
			MODE_SINGLE: return GATED_SINGLE_MASK;
			MODE_DUAL_A: return GATED_LAYOUT_A_MASK;
			MODE_DUAL_B: return GATED_LAYOUT_B_MASK;
			default:     return GATED_SINGLE_MASK;
		endcase
	endfunction

endpackage

// ### verilog/buffer_link_if.sv
// Pins between the memory controller end and the registered buffer
`timescale 1ns/1ps
interface buffer_link_if;
	logic        link_clk;
	logic        reset_n;
	logic        fanout_select;
	logic        layout_select;
	logic        secondary_chip_select_n;
	logic [24:0] registered_inputs;

	modport buffer_end (
		input link_clk,
		input reset_n,
		input fanout_select,
		input layout_select,
		input secondary_chip_select_n,
		input registered_inputs
	);

	modport controller_end (
		output link_clk,
		output reset_n,
		output fanout_select,
		output layout_select,
		output secondary_chip_select_n,
		output registered_inputs
	);
endinterface

// ### verilog/pin_sync.sv
// Two-stage synchroniser for a group of pins from another domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Pins and their synchronised copy
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] synced
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_type;

	sync_state_type state;
	sync_state_type next_state;

	// First stage feeds only the second stage
	always_comb begin
		next_state.first  = pins;
		next_state.second = state.first;
		if (reset) begin
			next_state = '0;
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	assign synced = state.second;

endmodule

// ### verilog/registered_buffer.sv
// Configurable registered buffer: captures link inputs, drives banks A/B
`timescale 1ns/1ps
// Function
// - Capture inputs on link clock rising edge
// - Fanout low: 25 bits; high: 14 dual
// - Layout select picks dual arrangement A or B
// - System ties config selects, never changes them; controller changes them only in reset
// - Single mode drives three unused outputs low
// - Reset clears register, outputs low, receivers off
// - Reset acts without waiting for capture edge
// - Outputs stay low after release, inputs low
// - System holds reset low through power-up
// - Inputs may float while reset is low
// - Reset and config selects never float
// - Both chip selects high freeze gated outputs
// - Reset overrides chip-select gating
// - Secondary select tied low disables gating
// - Enable, termination, select bits never frozen
// - Gated input set depends on mode
// - Gated outputs follow the same sets
// - Unused positions ignored, their outputs low
// - Either 25 single or 14 dual bits
module registered_buffer
	import buffer_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Link from the memory controller
	buffer_link_if.buffer_end link,
	// Outputs to the memory devices
	output logic      [13:0] registered_outputs_a,
	output logic      [13:0] registered_outputs_b
);

	localparam int SYNC_BITS = DATA_BITS + 5;

	typedef struct packed {
		logic        clk_prev;
		logic [1:0]  rx_count;
		logic        rx_on;
		logic [24:0] bits;
		logic [13:0] out_a;
		logic [13:0] out_b;
	} buffer_state_type;

	buffer_state_type state;
	buffer_state_type next_state;

	logic [SYNC_BITS-1:0] pins;
	logic [SYNC_BITS-1:0] synced;

	// Synchronised pin copies
	logic        link_clk_s;
	logic        reset_n_s;
	logic        fanout_s;
	logic        layout_s;
	logic        csr_n_s;
	logic [24:0] data_s;

	// Derived from the current configuration, chip selects and link clock
	mode_type    mode;
	logic [24:0] act;
	logic [24:0] gated;
	logic        hold;
	logic        rise;

	// Every pin, the link clock among them, comes from outside clk
	assign pins = {
		link.link_clk,
		link.reset_n,
		link.fanout_select,
		link.layout_select,
		link.secondary_chip_select_n,
		link.registered_inputs
	};

	pin_sync #(
		.WIDTH(SYNC_BITS)
	) input_sync (
		.clk   (clk),
		.reset (reset),
		.pins  (pins),
		.synced(synced)
	);

	// Split the synchronised word back into its pins
	assign link_clk_s = synced[SYNC_BITS-1];
	assign reset_n_s  = synced[SYNC_BITS-2];
	assign fanout_s   = synced[SYNC_BITS-3];
	assign layout_s   = synced[SYNC_BITS-4];
	assign csr_n_s    = synced[SYNC_BITS-5];
	assign data_s     = synced[DATA_BITS-1:0];

	// Mode and masks; config is static so no edge qualification needed
	assign mode  = decode_mode(fanout_s, layout_s);
	assign act   = active_mask(mode);
	assign gated = gated_mask(mode);

	// Freeze only when both chip selects are high at the edge
	assign hold  = data_s[PRIMARY_CS_BIT] & csr_n_s;

	// Rising edge of the sampled link clock is the capture point
	assign rise  = link_clk_s & ~state.clk_prev;

	// Bank B: a copy of A in dual modes, the upper word in single mode
	function automatic logic [13:0] route_b(input mode_type m,
		input logic [24:0] b);
		if (m == MODE_SINGLE) begin
			// Positions 1, 4 and 7 of bank B have no bit here
			return {b[24:18], 1'b0, b[17:16], 1'b0, b[15:14], 1'b0};
		end
		return b[13:0];
	endfunction

	// Capture, gating and output staging
	always_comb begin
		next_state          = state;
		next_state.clk_prev = link_clk_s;

		if (reset || !reset_n_s) begin
			// Clear immediately on the sampled level, no link edge needed
			next_state          = '0;
			next_state.clk_prev = link_clk_s;
		end else begin
			// Receivers wake up some time after the release
			if (!state.rx_on) begin
				next_state.rx_count = state.rx_count + 2'h1;
				if (state.rx_count == RX_ACTIVE_CYCLES[1:0] - 2'h1) begin
					next_state.rx_on = 1'b1;
				end
			end

			// Edges before the receivers are on are dropped, which
			// also keeps floating pins out of the register
			if (rise && state.rx_on) begin
				// Gated bits keep old value when both selects are high
				next_state.bits =
					(data_s & act & ~(gated & {25{hold}})) |
					(state.bits & act & gated & {25{hold}});
			end

			// Positions unused by the mode stay cleared
			next_state.bits = next_state.bits & act;
		end

		// Outputs change only together with the register
		next_state.out_a = next_state.bits[13:0];
		next_state.out_b = route_b(mode, next_state.bits);
		if (reset || !reset_n_s) begin
			next_state.out_a = '0;
			next_state.out_b = '0;
		end
	end

	// Single state register
	always_ff @(posedge clk) begin
		state <= next_state;
	end

	// Outputs straight from flip-flops
	assign registered_outputs_a = state.out_a;
	assign registered_outputs_b = state.out_b;

endmodule

// ### verilog/buffer_controller.sv
// Memory controller end: makes the link clock and drives buffer inputs
`timescale 1ns/1ps
module buffer_controller
	import buffer_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Software register port
	input  wire logic [3:0]  address,
	input  wire logic [31:0] write_data,
	input  wire logic        write_strobe,
	input  wire logic        read_strobe,
	output logic      [31:0] read_data,
	// Link to the buffer
	buffer_link_if.controller_end link
);

	typedef struct packed {
		logic [1:0]  div;
		logic        link_clk;
		logic        reset_n;
		logic [2:0]  control;
		logic [24:0] pending;
		logic        pending_csr_n;
		logic [24:0] inputs;
		logic        csr_n;
		logic [15:0] edges;
		logic [31:0] rdata;
	} ctrl_state_type;

	ctrl_state_type state;
	ctrl_state_type next_state;
	logic           toggle;

	assign toggle = (state.div == LINK_HALF_CYCLES[1:0] - 2'h1);

	// Divider, pin staging and register access
	always_comb begin
		next_state       = state;
		next_state.rdata = '0;
		next_state.div   = toggle ? 2'h0 : state.div + 2'h1;

		if (toggle) begin
			next_state.link_clk = ~state.link_clk;
			if (state.link_clk) begin
				// Change pins at the falling edge, half a period of setup
				next_state.inputs = state.reset_n ? state.pending : '0;
				next_state.csr_n  = state.pending_csr_n;
			end else if (state.reset_n) begin
				next_state.edges = state.edges + 16'h0001;
			end
		end

		if (write_strobe) begin
			case (address)
				CONTROL_OFFSET: begin
					// Config only moves while the buffer is held in reset
					if (!state.reset_n) begin
						next_state.control = write_data[2:0];
					end else begin
						next_state.control[CTRL_RELEASE_BIT] =
							write_data[CTRL_RELEASE_BIT];
					end
				end
				DATA_OFFSET:        next_state.pending = write_data[24:0];
				CHIP_SELECT_OFFSET: next_state.pending_csr_n = write_data[0];
				default: begin
				end
			endcase
		end
		next_state.reset_n = state.control[CTRL_RELEASE_BIT];

		if (read_strobe) begin
			case (address)
				CONTROL_OFFSET:     next_state.rdata = {29'h0, state.control};
				DATA_OFFSET:        next_state.rdata = {7'h0, state.pending};
				CHIP_SELECT_OFFSET: next_state.rdata = {31'h0, state.csr_n};
				STATUS_OFFSET:
					next_state.rdata = {15'h0, state.reset_n, state.edges};
				default:            next_state.rdata = '0;
			endcase
		end

		if (reset) begin
			next_state               = '0; // buffer held in reset
			next_state.control       = CONTROL_RESET;
			next_state.pending       = DATA_RESET;
			next_state.pending_csr_n = CHIP_SELECT_RESET;
			next_state.csr_n         = CHIP_SELECT_RESET;
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	// Link pins and read data from flip-flops
	assign read_data                    = state.rdata;
	assign link.link_clk                = state.link_clk;
	assign link.reset_n                 = state.reset_n;
	assign link.fanout_select           = state.control[CTRL_FANOUT_BIT];
	assign link.layout_select           = state.control[CTRL_LAYOUT_BIT];
	assign link.secondary_chip_select_n = state.csr_n;
	assign link.registered_inputs       = state.inputs;

endmodule

// ### verification/buffer_link_props.sv
// Properties of the link pins and of the buffer's output banks
`timescale 1ns/1ps
module buffer_link_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Link pins
	input wire logic        link_clk,
	input wire logic        reset_n,
	input wire logic        fanout_select,
	input wire logic        layout_select,
	input wire logic        secondary_chip_select_n,
	input wire logic [24:0] registered_inputs,
	// Output banks
	input wire logic [13:0] registered_outputs_a,
	input wire logic [13:0] registered_outputs_b
);
	logic [13:0] gm;
	logic [27:0] q;

	// Gated bank A bits; single mode shares the layout A set
	assign gm = (fanout_select && layout_select) ? 14'h1BBF : 14'h3FB6;
	assign q = {registered_outputs_a, registered_outputs_b};

	default clocking @(posedge clk); endclocking
	default disable iff (reset || !reset_n);

	a_dual_copies: assert property (
		fanout_select |-> registered_outputs_a == registered_outputs_b)
		else $error("bank copies differ");
	a_unused_low: assert property (
		!fanout_select |-> (registered_outputs_b & 14'h0049) == 14'h0000)
		else $error("unused output high");
	a_reset_clears: assert property (
		disable iff (reset) $fell(reset_n) |-> ##[1:4] q == 28'h0000000)
		else $error("reset did not clear outputs");
	a_reset_holds: assert property (
		disable iff (reset)
		!reset_n && !$past(reset_n, 4) |-> q == 28'h0000000)
		else $error("output high during reset");
	a_release_low: assert property (
		disable iff (reset) $rose(reset_n) |-> (q == 28'h0000000)[*3])
		else $error("glitch after release");
	a_config_static: assert property (
		$past(reset_n) |-> $stable(fanout_select) && $stable(layout_select))
		else $error("config select moved");
	a_inputs_at_fall: assert property (
		$past(reset_n) && $changed(registered_inputs) |-> $fell(link_clk))
		else $error("inputs moved off falling edge");
	// Gated bits hold over the whole capture window
	a_gated_freeze: assert property (
		$rose(link_clk) && $past(reset_n, 5) && registered_inputs[6] &&
		secondary_chip_select_n |=> $stable(registered_outputs_a & gm)[*6])
		else $error("gated output changed");
	a_select_follows: assert property (
		$rose(link_clk) && $past(reset_n, 5) |-> ##5
		registered_outputs_a[6] == $past(registered_inputs[6], 5))
		else $error("select output stale");

	c_frozen: cover property ($rose(link_clk) && registered_inputs[6] &&
		secondary_chip_select_n);
	c_layout_b: cover property (layout_select && registered_outputs_a != 0);
	c_single: cover property (!fanout_select && registered_outputs_b != 0);
endmodule

// ### verification/tb.sv
// Self-checking bench: controller end driving the buffer end
`timescale 1ns/1ps
module tb import buffer_pkg::*;;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  address = 4'h0;
	logic [31:0] write_data = 32'h0;
	logic        write_strobe = 1'b0;
	logic        read_strobe = 1'b0;
	logic [31:0] read_data;
	logic [13:0] registered_outputs_a;
	logic [13:0] registered_outputs_b;
	logic        rd_pend = 1'b0;
	logic        look = 1'b0;
	logic [31:0] rq[$];
	logic [56:0] oq[$];
	int          error_cnt = 0;
	int          n_compared = 0;
	int          cyc = 0;

	buffer_link_if buffer_link_if_i ();
	buffer_controller buffer_controller_i (.clk(clk), .reset(reset),
		.address(address), .write_data(write_data),
		.write_strobe(write_strobe), .read_strobe(read_strobe),
		.read_data(read_data), .link(buffer_link_if_i));
	registered_buffer registered_buffer_i (.clk(clk), .reset(reset),
		.link(buffer_link_if_i), .registered_outputs_a(registered_outputs_a),
		.registered_outputs_b(registered_outputs_b));
	buffer_link_props buffer_link_props_i (.clk(clk), .reset(reset),
		.link_clk(buffer_link_if_i.link_clk),
		.reset_n(buffer_link_if_i.reset_n),
		.fanout_select(buffer_link_if_i.fanout_select),
		.layout_select(buffer_link_if_i.layout_select),
		.secondary_chip_select_n(buffer_link_if_i.secondary_chip_select_n),
		.registered_inputs(buffer_link_if_i.registered_inputs),
		.registered_outputs_a(registered_outputs_a),
		.registered_outputs_b(registered_outputs_b));

	always #50 clk = ~clk;

	task automatic chk(string nm, logic [56:0] seen, logic [56:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Strobes drop for a cycle so no signal is set twice per step
	task automatic wr(logic [3:0] a, logic [31:0] d);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clk);
		write_strobe <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(logic [3:0] a, logic [31:0] e);
		address <= a;
		read_strobe <= 1'b1;
		rq.push_back(e);
		@(posedge clk);
		read_strobe <= 1'b0;
		@(posedge clk);
	endtask

	// Register model: masked capture, gated bits kept when frozen
	function automatic logic [24:0] nxt(logic [24:0] r, d, logic f, l, z);
		logic [24:0] gm;
		gm = !z ? 25'h0 : !f ? GATED_SINGLE_MASK :
			l ? GATED_LAYOUT_B_MASK : GATED_LAYOUT_A_MASK;
		return (d & (f ? ACTIVE_DUAL_MASK : ACTIVE_SINGLE_MASK) & ~gm) |
			(r & gm);
	endfunction

	task automatic exp_out(logic [24:0] r, d, logic f, l, rn, cs);
		logic [13:0] b;
		b = f ? r[13:0] : {r[24:18], 1'b0, r[17:16], 1'b0, r[15:14], 1'b0};
		oq.push_back({r[13:0], b, d, f, l, rn, cs});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
		@(posedge clk);
	endtask

	// Oldest note first, against what the outputs show
	always @(posedge clk) begin
		rd_pend <= read_strobe;
		if (rd_pend)
			chk("read_data", {25'h0, read_data}, {25'h0, rq.pop_front()});
		if (look)
			chk("link", {registered_outputs_a, registered_outputs_b,
				buffer_link_if_i.registered_inputs,
				buffer_link_if_i.fanout_select, buffer_link_if_i.layout_select,
				buffer_link_if_i.reset_n,
				buffer_link_if_i.secondary_chip_select_n},
				oq.pop_front());
	end

	// Hang guard, about two and a half times the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			complete_run();
		end
	end

	initial begin
		logic [24:0] r;
		logic [24:0] d;
		logic        f;
		logic        l;
		logic        cs;
		logic [24:0] p;
		int          s;
		s = $urandom(32'hdd5a);
		cs = 1'b0;
		// Buffer reset pin stays low until software releases it
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// Reset values, unmapped address last
		for (int i = 0; i < 5; i++)
			rd((i == 4) ? 4'hF : 4'(i), 32'h0);
		for (int m = 0; m < 3; m++) begin
			f = (m != 0);
			l = (m == 2);
			wr(DATA_OFFSET, 32'h0);
			wr(CONTROL_OFFSET, {29'h0, l, f, 1'b0});
			wr(CONTROL_OFFSET, {29'h0, l, f, 1'b1});
			r = 25'h0;
			p = 25'h0;
			repeat (24) @(posedge clk);
			exp_out(r, 25'h0, f, l, 1'b1, cs);
			// Second pass always freezes
			for (int j = 0; j < 6; j++) begin
				d = 25'($urandom);
				cs = (j == 1) | 1'($urandom);
				if (j == 1)
					d[PRIMARY_CS_BIT] = 1'b1;
				// One pin group per step: a split update would be captured
				wr(CHIP_SELECT_OFFSET, {31'h0, cs});
				repeat (24) @(posedge clk);
				r = nxt(r, p, f, l, p[PRIMARY_CS_BIT] & cs);
				rd(CHIP_SELECT_OFFSET, {31'h0, cs});
				wr(DATA_OFFSET, {7'h0, d});
				wr(4'hF, $urandom);
				rd(DATA_OFFSET, {7'h0, d});
				repeat (24) @(posedge clk);
				r = nxt(r, d, f, l, d[PRIMARY_CS_BIT] & cs);
				p = d;
				exp_out(r, d, f, l, 1'b1, cs);
			end
			// Mode bits are ignored while the link runs
			wr(CONTROL_OFFSET, {29'h0, ~l, ~f, 1'b1});
			rd(CONTROL_OFFSET, {29'h0, l, f, 1'b1});
			wr(CONTROL_OFFSET, {29'h0, l, f, 1'b0});
			repeat (8) @(posedge clk);
			exp_out(25'h0, 25'h0, f, l, 1'b0, cs);
		end
		complete_run();
	end
endmodule
